// File: src/mtp_consts.vh
// constants of the motor thermal protection block
`ifndef MTP_CONSTS_VH
`define MTP_CONSTS_VH
// ***********************************************************
// register map (word index on the plain register port)
// ***********************************************************
`define MTP_A_CTRL 4'h0
`define MTP_A_MODE0 4'h1
`define MTP_A_RATED0 4'h5
`define MTP_A_RFREQ 4'h9
`define MTP_A_FLIM 4'hA
`define MTP_A_WLIM 4'hB
`define MTP_A_TC 4'hC
`define MTP_A_STAT 4'hD
`define MTP_A_MASK 4'hE
`define MTP_A_STATE 4'hF
// ***********************************************************
// field positions and reset values
// ***********************************************************
`define MTP_CTRL_FCLR 0
`define MTP_ST_FAULT 0
`define MTP_ST_WARN 1
`define MTP_TC_ST_LSB 0
`define MTP_TC_MT_LSB 4
`define MTP_TC_RST 8'h84
`define MTP_FLIM_RST 9'h000
`define MTP_FLIM_MAX 9'h12C
`define MTP_WLIM_RST 7'h50
`define MTP_WLIM_MIN 7'h06
`define MTP_WLIM_MAX 7'h64
// ***********************************************************
// protection modes
// ***********************************************************
`define MTP_M_OFF 8'h00
`define MTP_M_K_MUL_ERR 8'h01
`define MTP_M_K_SGL_ERR 8'h02
`define MTP_M_K_MUL_WRN 8'h0B
`define MTP_M_K_SGL_WRN 8'h16
`define MTP_M_I2_SGL_ERR 8'h2A
`define MTP_M_I2_MUL_WRN 8'h33
`define MTP_M_I2_SGL_WRN 8'h34
`define MTP_M_I2_MUL_BOTH 8'h3D
`define MTP_M_I2_SGL_BOTH 8'h3E
`define MTP_M_K_MUL_ERR_L 8'h65
`define MTP_M_K_SGL_ERR_L 8'h66
`define MTP_M_K_MUL_WRN_L 8'h6F
`define MTP_M_K_SGL_WRN_L 8'h7A
// ***********************************************************
// thresholds, weighting and codes
// ***********************************************************
`define MTP_PCT_100 8'h64
`define MTP_STATOR_TRIP 8'h78
`define MTP_MOTOR_TRIP 8'h66
`define MTP_FSCALE 10'h320
`define MTP_FACT_TWO 10'h200
`define MTP_FACT_STEP 10'h020
`define MTP_NSTEPS 4'h8
`define MTP_FRAC 8
`define MTP_FAULT_CODE 20'hF_0401
`define MTP_WARN_CODE 20'hA_0200
`endif

// File: src/mtp_top.v
// motor thermal protection: overload switch model and two-stage thermal model
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "mtp_consts.vh"
// Notes on behaviour
// RL1 - multi-motor: one accumulator per data set
// RL2 - inactive sets decay with zero input
// RL3 - single-motor: one accumulator, always fed
// RL4 - set change swaps limits, keeps thermal value
// RL5 - latching modes save and restore state
// RL6 - frequency limit zero to 300 percent, default zero
// RL7 - current weighted two at 0 Hz, one above limit
// RL8 - trigger drives indication and digital output
// RL9 - mode setting held per data set
// RL10 - model input is squared current ratio
// RL11 - stator lag, trip above 120 percent
// RL12 - motor lag on stator output, trip at 102
// RL13 - both lags compared with one alarm limit
// RL14 - mode zero disables protection
// RL15 - error variants switch off with fault code
// RL16 - warning variants raise warning code only
// RL17 - warning limit 6 to 100, default 80
// RL18 - weighting stepped monotonically over frequency ratio
module mtp_top #(
    parameter CUR_W = 12,
    parameter FREQ_W = 12,
    parameter NSETS = 4,
    parameter DS_W = 2
) (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // measurement and data set from the drive
    input wire [CUR_W-1:0] cur_in,
    input wire [FREQ_W-1:0] freq_in,
    input wire sample_stb,
    input wire [DS_W-1:0] ds_sel,
    // power supervision
    input wire pwr_save,
    input wire pwr_restore,
    input wire nv_init,
    // protection results
    output reg fault_off,
    output reg trip_ind,
    output reg dout_warn,
    output reg [19:0] overload_fault_code,
    output reg [19:0] overload_warning_code,
    output wire irq
);
    localparam SQ_W = 2 * CUR_W + 2;
    localparam SW = SQ_W + `MTP_FRAC;
    localparam CW = SW + 8;
    // ***********************************************************
    // shared settings
    // ***********************************************************
    reg [FREQ_W-1:0] rfreq_q;
    reg [8:0] flim_q;
    reg [6:0] wlim_q;
    reg [7:0] tc_q;
    reg [1:0] stat_q;
    reg [1:0] mask_q;
    reg fault_q;
    reg warn_q;
    reg ind_q;
    wire wr_ctrl = reg_wr && (reg_addr == `MTP_A_CTRL);
    wire [3:0] st_sh = tc_q[`MTP_TC_ST_LSB +: 4];
    wire [3:0] mt_sh = tc_q[`MTP_TC_MT_LSB +: 4];
    // settings writes; upper bits beyond the field are dropped, then out-of-range values are clamped, never refused
    always @(posedge core_clk) begin
        if (sys_rst) begin
            rfreq_q <= {FREQ_W{1'b0}};
            flim_q <= `MTP_FLIM_RST;
            wlim_q <= `MTP_WLIM_RST;
            tc_q <= `MTP_TC_RST;
            mask_q <= 2'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `MTP_A_RFREQ: rfreq_q <= reg_wdata[FREQ_W-1:0];
                `MTP_A_FLIM: flim_q <= (reg_wdata[8:0] > `MTP_FLIM_MAX) ? `MTP_FLIM_MAX : reg_wdata[8:0]; // [RL6]
                `MTP_A_WLIM: begin
                    if (reg_wdata[6:0] < `MTP_WLIM_MIN) // [RL17]
                        wlim_q <= `MTP_WLIM_MIN;
                    else if (reg_wdata[6:0] > `MTP_WLIM_MAX)
                        wlim_q <= `MTP_WLIM_MAX;
                    else
                        wlim_q <= reg_wdata[6:0];
                end
                `MTP_A_TC: tc_q <= reg_wdata[7:0];
                `MTP_A_MASK: mask_q <= reg_wdata[1:0];
                default: rfreq_q <= rfreq_q;
            endcase
        end
    end
    // ***********************************************************
    // mode decode
    // ***********************************************************
    // flags: {kchar, i2t, multi, err, warn, latch}
    function [5:0] mtp_decode;
        input [7:0] m;
        begin
            case (m)
                `MTP_M_K_MUL_ERR: mtp_decode = 6'b101100;
                `MTP_M_K_SGL_ERR: mtp_decode = 6'b100100;
                `MTP_M_K_MUL_WRN: mtp_decode = 6'b101010;
                `MTP_M_K_SGL_WRN: mtp_decode = 6'b100010;
                `MTP_M_K_MUL_ERR_L: mtp_decode = 6'b101101;
                `MTP_M_K_SGL_ERR_L: mtp_decode = 6'b100101;
                `MTP_M_K_MUL_WRN_L: mtp_decode = 6'b101011;
                `MTP_M_K_SGL_WRN_L: mtp_decode = 6'b100011;
                `MTP_M_I2_SGL_ERR: mtp_decode = 6'b010100;
                `MTP_M_I2_MUL_WRN: mtp_decode = 6'b011010;
                `MTP_M_I2_SGL_WRN: mtp_decode = 6'b010010;
                `MTP_M_I2_MUL_BOTH: mtp_decode = 6'b011110;
                `MTP_M_I2_SGL_BOTH: mtp_decode = 6'b010110;
                default: mtp_decode = 6'b000000; // off and unknown codes disable
            endcase
        end
    endfunction
    // first-order lag step; the decay always moves by at least one lsb so a state reaches zero
    function [SW-1:0] mtp_pt1;
        input [SW-1:0] x;
        input [SW-1:0] u;
        input [3:0] sh;
        reg [SW-1:0] d;
        begin
            d = (u >= x) ? ((u - x) >> sh) : ((x - u) >> sh);
            if (u >= x)
                mtp_pt1 = x + d;
            else if (d == {SW{1'b0}})
                mtp_pt1 = x - {{(SW-1){1'b0}}, 1'b1};
            else
                mtp_pt1 = x - d;
        end
    endfunction
    // ***********************************************************
    // low-frequency current weighting
    // ***********************************************************
    wire [8:0] step_hit;
    genvar k;
    // ratio freq/limit compared against eighths; cheaper than a divider and monotonic
    generate
        for (k = 1; k <= 8; k = k + 1) begin : g_step
            wire [25:0] lhs = freq_in * `MTP_FSCALE;
            wire [25:0] rhs = flim_q * rfreq_q * k[3:0];
            assign step_hit[k-1] = (lhs >= rhs); // [RL18]
        end
    endgenerate
    assign step_hit[8] = 1'b0;
    reg [3:0] nstep;
    integer j;
    always @* begin
        nstep = 4'h0;
        for (j = 0; j < 8; j = j + 1)
            nstep = nstep + {3'h0, step_hit[j]};
    end
    // factor 2.0 at 0 Hz down to 1.0 at or above the limit; limit zero gives 1.0
    wire [9:0] factor = `MTP_FACT_TWO - `MTP_FACT_STEP * {6'h0, nstep}; // [RL7]
    wire [CUR_W+9:0] cur_x = cur_in * factor;
    wire [CUR_W:0] cur_w = cur_x[CUR_W+`MTP_FRAC:`MTP_FRAC];
    wire [SQ_W-1:0] sq_w = cur_w * cur_w;
    wire [SQ_W-1:0] sq_raw = cur_in * cur_in; // [RL10] full-width square
    // ***********************************************************
    // per data set state
    // ***********************************************************
    wire [NSETS*8-1:0] mode_all;
    wire [NSETS*CUR_W-1:0] rated_all;
    wire [NSETS*SW-1:0] kacc_all;
    wire [NSETS*SW-1:0] sf_all;
    wire [NSETS*SW-1:0] mf_all;
    wire [5:0] fl_act = mtp_decode(mode_all[ds_sel*8 +: 8]); // [RL9]
    wire kchar = fl_act[5];
    wire i2t = fl_act[4];
    wire multi = fl_act[3];
    wire latch = fl_act[0];
    wire [DS_W-1:0] acc_idx = multi ? ds_sel : {DS_W{1'b0}};
    genvar g;
    generate
        for (g = 0; g < NSETS; g = g + 1) begin : g_set
            reg [7:0] mode_q;
            reg [CUR_W-1:0] rated_q;
            reg [SW-1:0] kacc_q;
            reg [SW-1:0] sf_q;
            reg [SW-1:0] mf_q;
            reg [SW-1:0] nv_k;
            reg [SW-1:0] nv_s;
            reg [SW-1:0] nv_m;
            wire fed = multi ? (ds_sel == g) : (g == 0); // [RL1] [RL3]
            wire [SW-1:0] u_k = fed ? {sq_w, {`MTP_FRAC{1'b0}}} : {SW{1'b0}}; // [RL2]
            wire [SW-1:0] u_s = fed ? {sq_raw, {`MTP_FRAC{1'b0}}} : {SW{1'b0}};
            wire hold = !multi && (g != 0);
            // per set settings over the register port
            always @(posedge core_clk) begin
                if (sys_rst) begin
                    mode_q <= `MTP_M_OFF;
                    rated_q <= {CUR_W{1'b0}};
                end else if (reg_wr && (reg_addr == `MTP_A_MODE0 + g)) begin
                    mode_q <= reg_wdata[7:0];
                end else if (reg_wr && (reg_addr == `MTP_A_RATED0 + g)) begin
                    rated_q <= reg_wdata[CUR_W-1:0];
                end
            end
            // thermal state; a set change between sets of one mode never touches it; single-motor moves only the limits, multi-motor also the accumulator
            always @(posedge core_clk) begin
                if (sys_rst) begin
                    kacc_q <= {SW{1'b0}};
                    sf_q <= {SW{1'b0}};
                    mf_q <= {SW{1'b0}};
                end else if (pwr_restore && latch) begin
                    kacc_q <= nv_k; // [RL5]
                    sf_q <= nv_s;
                    mf_q <= nv_m;
                end else if (!kchar && !i2t) begin
                    kacc_q <= {SW{1'b0}}; // [RL14]
                    sf_q <= {SW{1'b0}};
                    mf_q <= {SW{1'b0}};
                end else if (sample_stb && !hold) begin
                    kacc_q <= kchar ? mtp_pt1(kacc_q, u_k, mt_sh) : {SW{1'b0}}; // [RL4]
                    sf_q <= i2t ? mtp_pt1(sf_q, u_s, st_sh) : {SW{1'b0}}; // [RL11]
                    mf_q <= i2t ? mtp_pt1(mf_q, sf_q, mt_sh) : {SW{1'b0}}; // [RL12]
                end
            end
            // retained copy; outlives sys_rst on purpose and is cleared only by nv_init
            always @(posedge core_clk) begin
                if (nv_init) begin
                    nv_k <= {SW{1'b0}};
                    nv_s <= {SW{1'b0}};
                    nv_m <= {SW{1'b0}};
                end else if (pwr_save && latch) begin
                    nv_k <= kacc_q; // [RL5]
                    nv_s <= sf_q;
                    nv_m <= mf_q;
                end
            end
            assign mode_all[g*8 +: 8] = mode_q;
            assign rated_all[g*CUR_W +: CUR_W] = rated_q;
            assign kacc_all[g*SW +: SW] = kacc_q;
            assign sf_all[g*SW +: SW] = sf_q;
            assign mf_all[g*SW +: SW] = mf_q;
        end
    endgenerate
    // ***********************************************************
    // limit comparison on the active data set
    // ***********************************************************
    wire [CUR_W-1:0] r_act = rated_all[ds_sel*CUR_W +: CUR_W];
    wire [SQ_W-1:0] r_sq = r_act * r_act;
    wire [CW-1:0] lim = {8'h00, r_sq, {`MTP_FRAC{1'b0}}};
    wire [CW-1:0] k_x = {8'h00, kacc_all[acc_idx*SW +: SW]};
    wire [CW-1:0] s_x = {8'h00, sf_all[acc_idx*SW +: SW]} * `MTP_PCT_100;
    wire [CW-1:0] m_x = {8'h00, mf_all[acc_idx*SW +: SW]} * `MTP_PCT_100;
    wire k_over = kchar && (k_x > lim);
    wire s_trip = i2t && (s_x > lim * `MTP_STATOR_TRIP); // [RL11]
    wire m_trip = i2t && (m_x >= lim * `MTP_MOTOR_TRIP); // [RL12]
    wire i2_warn = i2t && ((s_x >= lim * wlim_q) || (m_x >= lim * wlim_q)); // [RL13]
    wire err_ev = fl_act[2] && (kchar ? k_over : (s_trip || m_trip)); // [RL15]
    wire warn_now = fl_act[1] && (kchar ? k_over : i2_warn); // [RL16]
    // ***********************************************************
    // trip state, outputs and interrupt
    // ***********************************************************
    // the switch-off stays until software clears it; a standing trip wins over the clear
    always @(posedge core_clk) begin
        if (sys_rst) begin
            fault_q <= 1'b0;
            warn_q <= 1'b0;
            ind_q <= 1'b0;
        end else begin
            if (err_ev)
                fault_q <= 1'b1; // [RL15]
            else if (wr_ctrl && reg_wdata[`MTP_CTRL_FCLR])
                fault_q <= 1'b0;
            warn_q <= warn_now; // [RL16]
            ind_q <= err_ev || warn_now;
        end
    end
    // indication and codes follow the trip state
    always @(posedge core_clk) begin
        if (sys_rst) begin
            fault_off <= 1'b0;
            trip_ind <= 1'b0;
            dout_warn <= 1'b0;
            overload_fault_code <= 20'h0_0000;
            overload_warning_code <= 20'h0_0000;
        end else begin
            fault_off <= fault_q;
            trip_ind <= fault_q || ind_q; // [RL8]
            dout_warn <= fault_q || ind_q; // [RL8]
            overload_fault_code <= fault_q ? `MTP_FAULT_CODE : 20'h0_0000;
            overload_warning_code <= warn_q ? `MTP_WARN_CODE : 20'h0_0000;
        end
    end
    // sticky events, write one to clear; a new event in the clear cycle is kept
    wire [1:0] ev = {warn_now && !warn_q, err_ev && !fault_q};
    wire [1:0] clr = (reg_wr && (reg_addr == `MTP_A_STAT)) ? reg_wdata[1:0] : 2'h0;
    always @(posedge core_clk) begin
        if (sys_rst)
            stat_q <= 2'h0;
        else
            stat_q <= (stat_q & ~clr) | ev;
    end
    assign irq = |(stat_q & mask_q);
    // ***********************************************************
    // read back, one cycle after the strobe and zero otherwise
    // ***********************************************************
    reg [15:0] rd_d;
    always @* begin
        rd_d = 16'h0000;
        case (reg_addr)
            `MTP_A_MODE0, `MTP_A_MODE0 + 4'h1, `MTP_A_MODE0 + 4'h2, `MTP_A_MODE0 + 4'h3:
                rd_d = {8'h00, mode_all[(reg_addr - `MTP_A_MODE0) * 8 +: 8]};
            `MTP_A_RATED0, `MTP_A_RATED0 + 4'h1, `MTP_A_RATED0 + 4'h2, `MTP_A_RATED0 + 4'h3:
                rd_d = {4'h0, rated_all[(reg_addr - `MTP_A_RATED0) * CUR_W +: CUR_W]};
            `MTP_A_RFREQ: rd_d = {4'h0, rfreq_q};
            `MTP_A_FLIM: rd_d = {7'h00, flim_q};
            `MTP_A_WLIM: rd_d = {9'h000, wlim_q};
            `MTP_A_TC: rd_d = {8'h00, tc_q};
            `MTP_A_STAT: rd_d = {14'h0000, stat_q};
            `MTP_A_MASK: rd_d = {14'h0000, mask_q};
            `MTP_A_STATE: rd_d = {10'h000, ds_sel, 1'b0, ind_q, warn_q, fault_q};
            default: rd_d = 16'h0000;
        endcase
    end
    always @(posedge core_clk) begin
        if (sys_rst)
            reg_rdata <= 16'h0000;
        else
            reg_rdata <= reg_rd ? rd_d : 16'h0000;
    end
endmodule

// File: testbench/mtp_top_properties.sv
// port-level checker for the motor thermal protection block
`timescale 1ns/100ps
`include "mtp_consts.vh"
module mtp_top_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // protection results
    input wire logic fault_off,
    input wire logic trip_ind,
    input wire logic dout_warn,
    input wire logic [19:0] overload_fault_code,
    input wire logic [19:0] overload_warning_code,
    input wire logic irq
);
    // ****
    // helpers and sequences
    // ****
    // plain wire, so a clear request can be negated safely
    wire clr_w = reg_wr && reg_addr == `MTP_A_CTRL && reg_wdata[`MTP_CTRL_FCLR];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd(logic [3:0] a);
        reg_rd && reg_addr == a;
    endsequence
    // ****
    // properties
    // ****
    a_fault_code: assert property (overload_fault_code == (fault_off ? `MTP_FAULT_CODE : 20'h0_0000))
        else $error("fault code disagrees with fault state");
    a_warn_code: assert property (overload_warning_code == 20'h0_0000 || overload_warning_code == `MTP_WARN_CODE)
        else $error("warning code holds a foreign value");
    a_ind_dout: assert property (trip_ind == dout_warn)
        else $error("indication and digital output differ");
    a_fault_ind: assert property (fault_off |-> trip_ind)
        else $error("fault without indication");
    a_fault_sticky: assert property (fault_off && !clr_w && !$past(clr_w) |=> fault_off)
        else $error("fault dropped without a clear");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside the answer cycle");
    a_wlim_range: assert property (s_rd(`MTP_A_WLIM) |=> reg_rdata >= 16'h0006 && reg_rdata <= 16'h0064)
        else $error("warning limit out of range");
    a_flim_range: assert property (s_rd(`MTP_A_FLIM) |=> reg_rdata <= 16'h012C)
        else $error("frequency limit out of range");
    a_ctrl_reads: assert property (s_rd(`MTP_A_CTRL) |=> reg_rdata == 16'h0000)
        else $error("control word reads nonzero");
    a_mask_irq: assert property (reg_wr && reg_addr == `MTP_A_MASK && reg_wdata[1:0] == 2'b00 |=> !irq)
        else $error("interrupt with all events masked");
endmodule
bind mtp_top mtp_top_properties u_mtp_top_properties (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fault_off(fault_off), .trip_ind(trip_ind), .dout_warn(dout_warn), .overload_fault_code(overload_fault_code),
    .overload_warning_code(overload_warning_code), .irq(irq));

// File: testbench/mtp_drive_model.sv
// drive side model: current, stator frequency and data set selection
`timescale 1ns/100ps
module mtp_drive_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // settings from the bench
    input wire logic run,
    input wire logic [11:0] cur_v,
    input wire logic [11:0] freq_v,
    input wire logic [1:0] ds_v,
    // measurement towards the block
    output logic [11:0] cur_in = 12'h000,
    output logic [11:0] freq_in = 12'h000,
    output logic sample_stb = 1'b0,
    output logic [1:0] ds_sel = 2'h0
);
    // one filter step per clock while running; no step while stopped, so state holds
    always @(posedge core_clk) begin
        if (sys_rst) begin
            sample_stb <= 1'b0;
            cur_in <= 12'h000;
            freq_in <= 12'h000;
            ds_sel <= 2'h0;
        end else begin
            sample_stb <= run;
            cur_in <= cur_v;
            freq_in <= freq_v;
            ds_sel <= ds_v;
        end
    end
endmodule

// File: testbench/testbench.sv
// self-checking bench for the motor thermal protection block
`timescale 1ns/100ps
`include "mtp_consts.vh"
module testbench;
    // ****
    // stimulus, instances and tasks
    // ****
    reg core_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg pwr_save = 1'b0;
    reg pwr_restore = 1'b0;
    reg nv_init = 1'b0;
    reg run = 1'b0;
    reg [11:0] cur_v = 12'h000;
    reg [11:0] freq_v = 12'h000;
    reg [1:0] ds_v = 2'h0;
    wire [15:0] reg_rdata;
    wire [11:0] cur_in;
    wire [11:0] freq_in;
    wire [1:0] ds_sel;
    wire sample_stb, fault_off, trip_ind, dout_warn, irq;
    wire [19:0] overload_fault_code;
    wire [19:0] overload_warning_code;
    integer fails = 0;
    integer checks = 0;
    integer m;
    // 50 MHz clock
    always #10 core_clk = ~core_clk;
    mtp_drive_model u_mtp_drive_model (.core_clk(core_clk), .sys_rst(sys_rst), .run(run), .cur_v(cur_v),
        .freq_v(freq_v), .ds_v(ds_v), .cur_in(cur_in), .freq_in(freq_in), .sample_stb(sample_stb), .ds_sel(ds_sel));
    mtp_top u_mtp_top (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cur_in(cur_in), .freq_in(freq_in),
        .sample_stb(sample_stb), .ds_sel(ds_sel), .pwr_save(pwr_save), .pwr_restore(pwr_restore),
        .nv_init(nv_init), .fault_off(fault_off), .trip_ind(trip_ind), .dout_warn(dout_warn),
        .overload_fault_code(overload_fault_code), .overload_warning_code(overload_warning_code), .irq(irq));
    task complete_run;
        begin
            if (fails == 0 && checks > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    // word compare, also for the result codes
    task chkw(input [19:0] g, input [19:0] e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task chkb(input g, input e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge core_clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask
    // read data stand only in the cycle after the strobe
    task rdc(input [3:0] a, input [15:0] e);
        begin
            @(posedge core_clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1 chkw({4'h0, reg_rdata}, {4'h0, e});
        end
    endtask
    task drv(input r, input [11:0] c, input [11:0] fq, input [1:0] d);
        begin
            @(posedge core_clk);
            run <= r;
            cur_v <= c;
            freq_v <= fq;
            ds_v <= d;
        end
    endtask
    task pul(input s, input r, input n);
        begin
            @(posedge core_clk);
            pwr_save <= s;
            pwr_restore <= r;
            nv_init <= n;
            @(posedge core_clk);
            {pwr_save, pwr_restore, nv_init} <= 3'b000;
        end
    endtask
    // wait for fault (f=1) or warning to reach e, or with hold watch it stay there
    task watch(input f, input e, input integer n, input hold);
        integer k;
        reg s;
        begin
            for (k = 0; k < n; k = k + 1) begin
                @(posedge core_clk);
                #1 s = f ? fault_off : dout_warn;
                if (hold ? s !== e : s === e) k = n;
            end
            chkb(f ? fault_off : dout_warn, e);
        end
    endtask
    // same mode in all sets, fast shifts, fault and events cleared
    task cfg(input [7:0] md, input [15:0] r0, input [15:0] r1);
        reg [3:0] j;
        begin
            for (j = 4'h0; j < 4'h4; j = j + 4'h1) begin
                wr(`MTP_A_MODE0 + j, {8'h00, md});
                wr(`MTP_A_RATED0 + j, (j == 4'h0) ? r0 : r1);
            end
            wr(`MTP_A_TC, 16'h0022);
            wr(`MTP_A_CTRL, 16'h0001);
            wr(`MTP_A_STAT, 16'h0003);
        end
    endtask
    // hang guard: the tests need well under 8000 cycles
    initial begin
        #400000;
        fails = fails + 1;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        pul(1'b0, 1'b0, 1'b1);
        rdc(`MTP_A_WLIM, 16'h0050);
        rdc(`MTP_A_FLIM, 16'h0000);
        rdc(`MTP_A_TC, 16'h0084);
        rdc(`MTP_A_MODE0, 16'h0000);
        wr(`MTP_A_FLIM, 16'h01FF);
        rdc(`MTP_A_FLIM, 16'h012C);
        wr(`MTP_A_WLIM, 16'h0002);
        rdc(`MTP_A_WLIM, 16'h0006);
        wr(`MTP_A_WLIM, 16'h007F);
        rdc(`MTP_A_WLIM, 16'h0064);
        wr(`MTP_A_STATE, 16'hFFFF);
        rdc(`MTP_A_STATE, 16'h0000);
        rdc(`MTP_A_CTRL, 16'h0000);
        wr(`MTP_A_FLIM, 16'h0000);
        // protection off: heavy current trips nothing
        cfg(`MTP_M_OFF, 16'h0001, 16'h0001);
        drv(1'b1, 12'h100, 12'h000, 2'h0);
        watch(1'b1, 1'b0, 200, 1'b1);
        chkb(trip_ind, 1'b0);
        // overload fault, code, interrupt, clear
        drv(1'b0, 12'h000, 12'h000, 2'h0);
        wr(`MTP_A_MASK, 16'h0001);
        cfg(`MTP_M_K_MUL_ERR, 16'h0001, 16'h0FFF);
        drv(1'b1, 12'h100, 12'h000, 2'h0);
        watch(1'b1, 1'b1, 300, 1'b0);
        chkw(overload_fault_code, `MTP_FAULT_CODE);
        chkb(dout_warn, 1'b1);
        chkb(irq, 1'b1);
        rdc(`MTP_A_STAT, 16'h0001);
        wr(`MTP_A_STAT, 16'h0001);
        #1 chkb(irq, 1'b0);
        wr(`MTP_A_MASK, 16'h0000);
        drv(1'b1, 12'h000, 12'h000, 2'h0);
        repeat (100) @(posedge core_clk);
        wr(`MTP_A_CTRL, 16'h0001);
        watch(1'b1, 1'b0, 10, 1'b0);
        // multi keeps a state per set and decays idle ones; single shares one
        for (m = 0; m < 2; m = m + 1) begin
            cfg(m ? `MTP_M_K_SGL_WRN : `MTP_M_K_MUL_WRN, 16'h0001, 16'h0FFF);
            drv(1'b1, 12'h010, 12'h000, 2'h0);
            watch(1'b0, 1'b1, 200, 1'b0);
            chkw(overload_warning_code, `MTP_WARN_CODE);
            chkb(fault_off, 1'b0);
            drv(1'b1, 12'h010, 12'h000, 2'h1);
            repeat (200) @(posedge core_clk);
            #1 chkb(dout_warn, 1'b0);
            drv(1'b1, 12'h000, 12'h000, 2'h0);
            repeat (4) @(posedge core_clk);
            #1 chkb(dout_warn, m == 1);
        end
        // weighting doubles the current at standstill, none above the limit
        cfg(`MTP_M_K_SGL_WRN, 16'h000A, 16'h000A);
        wr(`MTP_A_RFREQ, 16'h01F4);
        wr(`MTP_A_FLIM, 16'h0064);
        drv(1'b1, 12'h008, 12'h000, 2'h0);
        watch(1'b0, 1'b1, 300, 1'b0);
        drv(1'b1, 12'h008, 12'h258, 2'h0);
        watch(1'b0, 1'b0, 300, 1'b0);
        // latched state kept across a reset by save and restore
        cfg(`MTP_M_K_SGL_WRN_L, 16'h0001, 16'h0001);
        drv(1'b1, 12'h010, 12'h258, 2'h0);
        watch(1'b0, 1'b1, 200, 1'b0);
        drv(1'b0, 12'h000, 12'h258, 2'h0);
        pul(1'b1, 1'b0, 1'b0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        cfg(`MTP_M_K_SGL_WRN_L, 16'h0001, 16'h0001);
        #1 chkb(dout_warn, 1'b0);
        pul(1'b0, 1'b1, 1'b0);
        watch(1'b0, 1'b1, 10, 1'b0);
        pul(1'b0, 1'b0, 1'b1);
        pul(1'b0, 1'b1, 1'b0);
        watch(1'b0, 1'b0, 10, 1'b0);
        // squared ratio against the alarm limit and both trip thresholds
        wr(`MTP_A_WLIM, 16'h0006);
        cfg(`MTP_M_I2_SGL_WRN, 16'h000A, 16'h000A);
        drv(1'b1, 12'h005, 12'h000, 2'h0);
        watch(1'b0, 1'b1, 200, 1'b0);
        wr(`MTP_A_WLIM, 16'h0050);
        watch(1'b0, 1'b0, 200, 1'b0);
        cfg(`MTP_M_I2_SGL_BOTH, 16'h0014, 16'h0014);
        drv(1'b1, 12'h014, 12'h000, 2'h0);
        watch(1'b1, 1'b0, 300, 1'b1);
        drv(1'b1, 12'h015, 12'h000, 2'h0);
        watch(1'b1, 1'b1, 400, 1'b0);
        drv(1'b1, 12'h000, 12'h000, 2'h0);
        repeat (100) @(posedge core_clk);
        cfg(`MTP_M_I2_SGL_ERR, 16'h0014, 16'h0014);
        wr(`MTP_A_TC, 16'h0082);
        drv(1'b1, 12'h019, 12'h000, 2'h0);
        watch(1'b1, 1'b1, 40, 1'b0);
        complete_run;
    end
endmodule
